/* verilog/gcf_config_bank.sv */
// Configuration register bank: serial pin select, RS485 flow control,
// GPIO group mux, debounce/trigger and floppy resources.
// Assumes synchronous UART transmit-busy levels and asynchronous pins.
`timescale 1ns/1ns
// Contract
// - Data-line filter bit 3 zero filters serial data; one bypasses.
// - Clock-line filter bit 2 zero filters serial clock; one bypasses.
// - Select bit 1 zero gives lines 25/26; one gives two-wire data/clock.
// - Bits 7..4 enable RS485 autoflow for UARTs A, C, D, E.
// - Polarity bits 3..0 act only while matching enable bit set.
// - Set polarity bit inverts that UART's send-request pin behaviour.
// - Group-one register bit 7: second GPIO group open-drain 0, push-pull 1.
// - Bit 6: first GPIO group open-drain when 0, push-pull when 1.
// - Bit 2 enables thermal shutdown when one.
// - Two-bit select: tri/low, infrared, all GPIO, all UART B.
// - Bits 6..4 zero enable debouncer of lines 27, 26, 25.
// - Bits 2..0 select edge (0) or level (1) trigger for 27..25.
// - Activate bit 0 makes floppy controller active, default one.
// - Base registers set floppy I/O base 100h-FF8h, 8-byte aligned.
// - Interrupt register low four bits pick floppy IRQ, default 6.
module gcf_config_bank
  import gcf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Two-wire raw pins (asynchronous)
  input wire logic serialDataPin,
  input wire logic serialClockPin,
  // Two-wire pin routing
  output logic serialDataIn,
  output logic serialClockIn,
  output logic sharedPinsTwoWire,
  // UART transmit activity, one bit per UART A, C, D, E
  input wire logic [NUM_UART-1:0] uartTxBusy,
  input wire logic [NUM_UART-1:0] uartModemSendRequestN,
  output logic [NUM_UART-1:0] uartSendRequestN,
  // GPIO group control
  output logic gpioGroupOnePushPull,
  output logic gpioGroupTwoPushPull,
  output logic thermalShutdownOn,
  output logic [1:0] groupPinMode,
  output logic infraredSelected,
  output logic uartBSelected,
  output logic [NUM_LINE-1:0] debounceOn,
  output logic [NUM_LINE-1:0] levelTrigger,
  // Floppy resources
  output gcf_floppy_s floppyRes
);
  logic [7:0] pinSel_r;
  logic [7:0] flow_r;
  logic [7:0] mux_r;
  logic [7:0] deb_r;
  logic [7:0] testA_r;
  logic [7:0] testB_r;
  logic [7:0] act_r;
  logic [7:0] baseHi_r;
  logic [7:0] baseLo_r;
  logic [7:0] irq_r;
  logic [7:0] dma_r;
  logic [1:0] dataSync_r;
  logic [1:0] clkSync_r;
  logic [2:0] dataHist_r;
  logic [2:0] clkHist_r;
  logic dataFilt_r;
  logic clkFilt_r;
  logic [7:0] rdata_nxt;
  gcf_bus_s bus;

  assign bus = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

  // Register writes; reserved bits kept at zero by masks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSel_r <= RST_PIN_SEL;
      flow_r <= RST_FLOW;
      mux_r <= RST_MUX;
      deb_r <= RST_DEBOUNCE;
      testA_r <= RST_TEST;
      testB_r <= RST_TEST;
      act_r <= RST_ACTIVATE;
      baseHi_r <= RST_BASE_HI;
      baseLo_r <= RST_BASE_LO;
      irq_r <= RST_IRQ;
      dma_r <= RST_DMA;
    end else if (clkEn && bus.wr) begin
      case (bus.addr)
        OFF_PIN_SEL: pinSel_r <= bus.wdata & MSK_PIN_SEL;
        OFF_FLOW: flow_r <= bus.wdata;
        OFF_MUX: mux_r <= bus.wdata & MSK_MUX;
        OFF_DEBOUNCE: deb_r <= bus.wdata & MSK_DEBOUNCE;
        // Stored only; no function hangs on them
        OFF_TEST_A: testA_r <= bus.wdata;
        OFF_TEST_B: testB_r <= bus.wdata;
        OFF_ACTIVATE: act_r <= bus.wdata & MSK_ACTIVATE;
        OFF_BASE_HI: baseHi_r <= bus.wdata;
        OFF_BASE_LO: baseLo_r <= bus.wdata;
        OFF_IRQ: irq_r <= bus.wdata & MSK_IRQ;
        OFF_DMA: dma_r <= bus.wdata & MSK_DMA;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (bus.addr)
      OFF_PIN_SEL: rdata_nxt = pinSel_r;
      OFF_FLOW: rdata_nxt = flow_r;
      OFF_MUX: rdata_nxt = mux_r;
      OFF_DEBOUNCE: rdata_nxt = deb_r;
      OFF_TEST_A: rdata_nxt = testA_r;
      OFF_TEST_B: rdata_nxt = testB_r;
      OFF_ACTIVATE: rdata_nxt = act_r;
      OFF_BASE_HI: rdata_nxt = baseHi_r;
      OFF_BASE_LO: rdata_nxt = baseLo_r;
      OFF_IRQ: rdata_nxt = irq_r;
      OFF_DMA: rdata_nxt = dma_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stand one cycle only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= bus.rd ? rdata_nxt : 8'h00;
    end
  end

  // Pin synchronisers and three-sample agreement glitch filter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dataSync_r <= 2'h3;
      clkSync_r <= 2'h3;
      dataHist_r <= 3'h7;
      clkHist_r <= 3'h7;
      dataFilt_r <= 1'b1;
      clkFilt_r <= 1'b1;
    end else if (clkEn) begin
      dataSync_r <= {dataSync_r[0], serialDataPin};
      clkSync_r <= {clkSync_r[0], serialClockPin};
      dataHist_r <= {dataHist_r[1:0], dataSync_r[1]};
      clkHist_r <= {clkHist_r[1:0], clkSync_r[1]};
      // Level only changes once three samples agree
      if (dataHist_r == 3'h7) begin
        dataFilt_r <= 1'b1;
      end else if (dataHist_r == 3'h0) begin
        dataFilt_r <= 1'b0;
      end
      if (clkHist_r == 3'h7) begin
        clkFilt_r <= 1'b1;
      end else if (clkHist_r == 3'h0) begin
        clkFilt_r <= 1'b0;
      end
    end
  end

  // Two-wire input routing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialDataIn <= 1'b1;
      serialClockIn <= 1'b1;
      sharedPinsTwoWire <= 1'b0;
    end else if (clkEn) begin
      serialDataIn <= pinSel_r[POS_SDA_BYPASS] ? dataSync_r[1] : dataFilt_r;
      serialClockIn <= pinSel_r[POS_SCL_BYPASS] ? clkSync_r[1] : clkFilt_r;
      sharedPinsTwoWire <= pinSel_r[POS_I2C_SEL];
    end
  end

  // RS485 send-request per UART: bit order A, C, D, E maps to index 3..0
  genvar u;
  generate
    for (u = 0; u < NUM_UART; u++) begin : g_uart
      logic flowOn;
      logic invert;
      assign flowOn = flow_r[POS_FLOW_EN + u];
      assign invert = flowOn & flow_r[u];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          uartSendRequestN[u] <= 1'b1;
        end else if (clkEn) begin
          if (flowOn) begin
            // Active low while shifting, flipped when inverted
            uartSendRequestN[u] <= ~uartTxBusy[u] ^ invert;
          end else begin
            uartSendRequestN[u] <= uartModemSendRequestN[u];
          end
        end
      end
    end
  endgenerate

  // GPIO group controls
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpioGroupTwoPushPull <= 1'b0;
      gpioGroupOnePushPull <= 1'b0;
      thermalShutdownOn <= 1'b0;
      groupPinMode <= GRP_ALL_GPIO;
      infraredSelected <= 1'b0;
      uartBSelected <= 1'b0;
      debounceOn <= '1;
      levelTrigger <= '0;
    end else if (clkEn) begin
      gpioGroupTwoPushPull <= mux_r[POS_GRP2_PP];
      gpioGroupOnePushPull <= mux_r[POS_GRP1_PP];
      thermalShutdownOn <= mux_r[POS_THERMAL];
      groupPinMode <= mux_r[1:0];
      infraredSelected <= (mux_r[1:0] == GRP_INFRARED);
      uartBSelected <= (mux_r[1:0] == GRP_UART_B);
      // Index 2..0 is line 27..25
      debounceOn <= ~deb_r[POS_DEB_OFF +: NUM_LINE];
      levelTrigger <= deb_r[NUM_LINE-1:0];
    end
  end

  // Floppy resources; base low three bits forced to zero for alignment
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      floppyRes <= '{ioBase: 12'h3F0, irq: 4'h6, dmaChannel: 2'h2, dmaActive: 1'b1,
                     active: 1'b1};
    end else if (clkEn) begin
      floppyRes.active <= act_r[0];
      floppyRes.ioBase <= {baseHi_r[3:0], baseLo_r[7:3], 3'h0};
      floppyRes.irq <= irq_r[3:0];
      floppyRes.dmaChannel <= dma_r[1:0];
      floppyRes.dmaActive <= ~dma_r[2];
    end
  end
endmodule

/* verilog/gcf_pkg.sv */
// Package for the global configuration and floppy resource register bank.
// Assumes an 8-bit register port with one-cycle strobes on one clock.
package gcf_pkg;
  // Register offsets
  localparam logic [7:0] OFF_PIN_SEL = 8'h2A;
  localparam logic [7:0] OFF_FLOW = 8'h2B;
  localparam logic [7:0] OFF_MUX = 8'h2C;
  localparam logic [7:0] OFF_DEBOUNCE = 8'h2D;
  localparam logic [7:0] OFF_TEST_A = 8'h2E;
  localparam logic [7:0] OFF_TEST_B = 8'h2F;
  localparam logic [7:0] OFF_ACTIVATE = 8'h30;
  localparam logic [7:0] OFF_BASE_HI = 8'h60;
  localparam logic [7:0] OFF_BASE_LO = 8'h61;
  localparam logic [7:0] OFF_IRQ = 8'h70;
  localparam logic [7:0] OFF_DMA = 8'h74;
  // Reset values
  localparam logic [7:0] RST_PIN_SEL = 8'h00;
  localparam logic [7:0] RST_FLOW = 8'h00;
  localparam logic [7:0] RST_MUX = 8'h02;
  localparam logic [7:0] RST_DEBOUNCE = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_ACTIVATE = 8'h01;
  localparam logic [7:0] RST_BASE_HI = 8'h03;
  localparam logic [7:0] RST_BASE_LO = 8'hF0;
  localparam logic [7:0] RST_IRQ = 8'h06;
  localparam logic [7:0] RST_DMA = 8'h02;
  // Writable masks; reserved bits read zero
  localparam logic [7:0] MSK_PIN_SEL = 8'h0E;
  localparam logic [7:0] MSK_MUX = 8'hC7;
  localparam logic [7:0] MSK_DEBOUNCE = 8'h77;
  localparam logic [7:0] MSK_ACTIVATE = 8'h01;
  localparam logic [7:0] MSK_IRQ = 8'h0F;
  localparam logic [7:0] MSK_DMA = 8'h07;
  // Field positions
  localparam int POS_SDA_BYPASS = 3;
  localparam int POS_SCL_BYPASS = 2;
  localparam int POS_I2C_SEL = 1;
  localparam int POS_FLOW_EN = 4;
  localparam int POS_GRP2_PP = 7;
  localparam int POS_GRP1_PP = 6;
  localparam int POS_THERMAL = 2;
  localparam int POS_DEB_OFF = 4;
  localparam int NUM_UART = 4;
  localparam int NUM_LINE = 3;

  typedef enum logic [1:0] {
    GRP_TRI_LOW = 2'h0,
    GRP_INFRARED = 2'h1,
    GRP_ALL_GPIO = 2'h2,
    GRP_UART_B = 2'h3
  } gcf_group_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcf_bus_s;

  typedef struct packed {
    logic [11:0] ioBase;
    logic [3:0] irq;
    logic [1:0] dmaChannel;
    logic dmaActive;
    logic active;
  } gcf_floppy_s;
endpackage

/* test/gcf_config_bank_chk.sv */
// Checker for the configuration bank; shadows every register except the two test registers from writes.
// Assumes the bench drives the register port; clkEn low freezes the shadows too.
`timescale 1ns/1ns
module gcf_config_bank_chk
  import gcf_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk, resetn, clkEn, regWr, regRd,
  input wire logic [7:0] regAddr, regWdata, regRdata,
  // Pins and outputs
  input wire logic serialDataPin, serialClockPin, serialDataIn, serialClockIn,
  input wire logic sharedPinsTwoWire, gpioGroupOnePushPull, gpioGroupTwoPushPull,
  input wire logic thermalShutdownOn, infraredSelected, uartBSelected,
  input wire logic [3:0] uartTxBusy, uartModemSendRequestN, uartSendRequestN,
  input wire logic [1:0] groupPinMode,
  input wire logic [2:0] debounceOn, levelTrigger,
  input gcf_floppy_s floppyRes
);
  logic [7:0] pinS, flow, mux, deb, act, bhi, blo, irq, dma;
  logic [3:0] expN;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {pinS, flow, mux, deb} <= {RST_PIN_SEL, RST_FLOW, RST_MUX, RST_DEBOUNCE};
      {act, bhi, blo} <= {RST_ACTIVATE, RST_BASE_HI, RST_BASE_LO};
      {irq, dma} <= {RST_IRQ, RST_DMA};
    end else if (clkEn && regWr) begin
      case (regAddr)
        OFF_PIN_SEL: pinS <= regWdata & MSK_PIN_SEL;
        OFF_FLOW: flow <= regWdata;
        OFF_MUX: mux <= regWdata & MSK_MUX;
        OFF_DEBOUNCE: deb <= regWdata & MSK_DEBOUNCE;
        OFF_ACTIVATE: act <= regWdata & MSK_ACTIVATE;
        OFF_BASE_HI: bhi <= regWdata;
        OFF_BASE_LO: blo <= regWdata;
        OFF_IRQ: irq <= regWdata & MSK_IRQ;
        OFF_DMA: dma <= regWdata & MSK_DMA;
        default: ;
      endcase
    end
  end
  // Polarity only matters where autoflow is on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) expN <= 4'hF;
    else if (clkEn) expN <= (flow[7:4] & (~uartTxBusy ^ flow[3:0])) | (~flow[7:4] & uartModemSendRequestN);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  data_bypass_a: assert property (($rose(serialDataPin) && pinS[3]) ##1 pinS[3] [*3] |=> serialDataIn)
    else $error("data bypass too slow");
  clock_bypass_a: assert property (($rose(serialClockPin) && pinS[2]) ##1 pinS[2] [*3] |=> serialClockIn)
    else $error("clock bypass too slow");
  pin_route_a: assert property (sharedPinsTwoWire == $past(pinS[1]))
    else $error("shared pin routing wrong");
  send_req_a: assert property (uartSendRequestN == expN)
    else $error("send request level wrong");
  out_type_a: assert property ({gpioGroupTwoPushPull, gpioGroupOnePushPull, thermalShutdownOn} == $past({mux[7], mux[6], mux[2]}))
    else $error("output type or thermal wrong");
  group_sel_a: assert property ({groupPinMode, infraredSelected, uartBSelected} == $past({mux[1:0], mux[1:0] == 2'h1, mux[1:0] == 2'h3}))
    else $error("pin group mode wrong");
  deb_trig_a: assert property ({debounceOn, levelTrigger} == $past({~deb[6:4], deb[2:0]}))
    else $error("debounce or trigger wrong");
  floppy_res_a: assert property (floppyRes == $past({bhi[3:0], blo[7:3], 3'h0, irq[3:0], dma[1:0], ~dma[2], act[0]}))
    else $error("floppy resources wrong");
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  cover property (regWr && regAddr == OFF_FLOW && regWdata[7]);
  cover property (regWr && regAddr == OFF_DMA && regWdata[2]);
  cover property ($rose(serialDataPin) && pinS[3]);
endmodule
bind gcf_config_bank gcf_config_bank_chk u_chk (.*);

/* test/gcf_config_bank_tb.sv */
// Self-checking bench for the configuration bank, random register traffic.
// Assumes the checker file is compiled first and binds itself to the DUT.
`timescale 1ns/1ns
module gcf_config_bank_tb
  import gcf_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic regWr = 1'b0, regRd = 1'b0, dataPin = 1'b0, clockPin = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [7:0] tick = 8'h00;
  logic [3:0] busy = 4'h0, modem = 4'hF;
  logic [1:0] groupPinMode;
  logic infraredSelected, uartBSelected;
  gcf_floppy_s floppyRes;
  int seed = 30;
  int fails = 0;
  int n_compared = 0;
  localparam logic [7:0] OFFS [11] = '{OFF_PIN_SEL, OFF_FLOW, OFF_MUX, OFF_DEBOUNCE,
    OFF_TEST_A, OFF_TEST_B, OFF_ACTIVATE, OFF_BASE_HI, OFF_BASE_LO, OFF_IRQ, OFF_DMA};
  localparam logic [7:0] RSTS [11] = '{RST_PIN_SEL, RST_FLOW, RST_MUX, RST_DEBOUNCE,
    RST_TEST, RST_TEST, RST_ACTIVATE, RST_BASE_HI, RST_BASE_LO, RST_IRQ, RST_DMA};
  localparam logic [7:0] MSKS [11] = '{MSK_PIN_SEL, 8'hFF, MSK_MUX, MSK_DEBOUNCE,
    8'hFF, 8'hFF, MSK_ACTIVATE, 8'hFF, 8'hFF, MSK_IRQ, MSK_DMA};

  gcf_config_bank DUT (.clk(clk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .serialDataPin(dataPin), .serialClockPin(clockPin), .serialDataIn(), .serialClockIn(),
    .sharedPinsTwoWire(), .uartTxBusy(busy), .uartModemSendRequestN(modem),
    .uartSendRequestN(), .gpioGroupOnePushPull(), .gpioGroupTwoPushPull(),
    .thermalShutdownOn(), .groupPinMode(groupPinMode), .infraredSelected(infraredSelected),
    .uartBSelected(uartBSelected), .debounceOn(), .levelTrigger(), .floppyRes(floppyRes));

  always #2 clk = ~clk;
  // Slow pin toggles so both filter paths settle between edges
  always @(posedge clk) begin
    tick <= tick + 8'h01;
    dataPin <= tick[3];
    clockPin <= tick[4];
    busy <= 4'($random(seed));
    modem <= 4'($random(seed));
  end

  // DMA code 1xx leaves no channel active
  function automatic logic [2:0] dma_exp(input int c);
    return {c < 4, 2'(c)};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    check(32'(regRdata), 32'(exp));
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    int k;
    logic [7:0] d;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 11; i++) rd(OFFS[i], RSTS[i]);
    wr(8'h31, 8'hFF);
    rd(8'h31, 8'h00);
    // A write while frozen must not land
    clkEn <= 1'b0;
    wr(OFF_FLOW, 8'hFF);
    clkEn <= 1'b1;
    rd(OFF_FLOW, RST_FLOW);
    for (int n = 0; n < 80; n++) begin
      k = {$random(seed)} % 11;
      d = 8'($random(seed));
      if (k == 4 || k == 5) d = 8'h00;
      wr(OFFS[k], d);
      rd(OFFS[k], d & MSKS[k]);
      repeat (k) @(posedge clk);
    end
    for (int c = 0; c < 8; c++) begin
      wr(OFF_DMA, 8'(c));
      @(negedge clk);
      check(32'({floppyRes.dmaActive, floppyRes.dmaChannel}), 32'(dma_exp(c)));
      @(posedge clk);
      wr(OFF_MUX, 8'hC4 | 8'(c % 4));
      @(negedge clk);
      check(32'({groupPinMode, infraredSelected, uartBSelected}), 32'({2'(c), c % 4 == 1, c % 4 == 3}));
      @(posedge clk);
    end
    for (int b = 0; b < 2; b++) begin
      wr(OFF_BASE_HI, b ? 8'hFF : 8'h01);
      wr(OFF_BASE_LO, b ? 8'hFF : 8'h00);
      @(negedge clk);
      check(32'(floppyRes.ioBase), b ? 32'hFF8 : 32'h100);
      @(posedge clk);
    end
    wr(OFF_FLOW, 8'hF5);
    repeat (20) @(posedge clk);
    wr(OFF_FLOW, 8'h0F);
    wr(OFF_PIN_SEL, 8'h0E);
    repeat (80) @(posedge clk);
    give_verdict;
  end
  // Whole run needs at most about 1330 cycles, far below the 25000-cycle limit
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
endmodule
